// file: hdl/dicl_cfg.svh
// Register map, field positions, reset values and option codes
// Assumes inclusion by the drive input command logic files and their test bench
`ifndef DICL_CFG_SVH
`define DICL_CFG_SVH
`define DICL_ADDR_W 8
`define DICL_OFS_CTRL 8'h00
`define DICL_OFS_ACC1 8'h04
`define DICL_OFS_DEC1 8'h08
`define DICL_OFS_ACC2 8'h0c
`define DICL_OFS_DEC2 8'h10
`define DICL_OFS_METHOD 8'h14
`define DICL_OFS_DELAY 8'h18
`define DICL_OFS_MODE 8'h1c
`define DICL_OFS_POL 8'h20
`define DICL_OFS_ASSIGN 8'h24
`define DICL_OFS_STATUS 8'h28
`define DICL_OFS_IRQ_STAT 8'h2c
`define DICL_OFS_IRQ_CLR 8'h30
`define DICL_OFS_IRQ_EN 8'h34
`define DICL_OFS_HIST 8'h38
`define DICL_TERM_N 5
`define DICL_FUNC_W 8
`define DICL_FUNC_RAMP2 8'h09
`define DICL_FUNC_COAST 8'h0b
`define DICL_FUNC_FAULT 8'h0c
`define DICL_METHOD_TERM 2'h0
`define DICL_FAULT_CODE 8'h12
`define DICL_RAMP_W 16
`define DICL_DELAY_W 16
`define DICL_TICK_DIV 18'h3d090
`define DICL_TICK_W 18
`define DICL_TICK_ONE 18'h00001
`define DICL_DELAY_ONE 16'h0001
`define DICL_ASSIGN_RST 40'h000c0b0900
`define DICL_ACC_RST 16'h0064
`define DICL_DEC_RST 16'h0064
`define DICL_HIST_W 8
`define DICL_HIST_ONE 8'h01
`define DICL_HIST_MAX 8'hff
`define DICL_IRQ_W 3
`define DICL_IRQ_FAULT 0
`define DICL_IRQ_COAST 1
`define DICL_IRQ_RESUME 2
`define DICL_RESP_OKAY 2'h0
`define DICL_RESP_SLVERR 2'h2
`endif

// file: hdl/dicl_pkg.sv
// Types shared by the drive input command logic
// Assumes dicl_cfg.svh supplies all constants
package dicl_pkg;
  typedef enum logic [1:0] {
    DICL_STOPPED,
    DICL_RUNNING,
    DICL_COASTING,
    DICL_WAITING
  } dicl_state_t;
  typedef enum logic [1:0] {
    DICL_WR_IDLE,
    DICL_WR_RESP
  } dicl_wr_t;
endpackage

// file: hdl/dicl_term_sync.sv
// Terminal synchroniser, polarity and function decode
// Assumes terminals are asynchronous contacts; one clock domain
`timescale 1ns/1ps
`include "dicl_cfg.svh"
module dicl_term_sync
  import dicl_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [`DICL_TERM_N-1:0] term_in, // Raw terminals
  input wire logic [`DICL_TERM_N-1:0] pol_low, // 1 = active low
  input wire logic [`DICL_TERM_N*`DICL_FUNC_W-1:0] func_sel, // Per input
  output logic ramp2_lvl, // Second ramp asserted
  output logic coast_lvl, // Coast stop asserted
  output logic fault_rise // Fault off-to-on pulse
);
  logic [`DICL_TERM_N-1:0] meta_ff;
  logic [`DICL_TERM_N-1:0] sync_ff;
  logic [`DICL_TERM_N-1:0] act;
  logic [`DICL_TERM_N-1:0] is_ramp2;
  logic [`DICL_TERM_N-1:0] is_coast;
  logic [`DICL_TERM_N-1:0] is_fault;
  logic fault_lvl;
  logic fault_prev_ff;

  // Two-flop synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= term_in;
      sync_ff <= meta_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DICL_TERM_N; gi++) begin : g_term
      assign act[gi] = sync_ff[gi] ^ pol_low[gi];
      assign is_ramp2[gi] = act[gi] &&
        func_sel[gi*`DICL_FUNC_W +: `DICL_FUNC_W] == `DICL_FUNC_RAMP2;
      assign is_coast[gi] = act[gi] &&
        func_sel[gi*`DICL_FUNC_W +: `DICL_FUNC_W] == `DICL_FUNC_COAST;
      assign is_fault[gi] = act[gi] &&
        func_sel[gi*`DICL_FUNC_W +: `DICL_FUNC_W] == `DICL_FUNC_FAULT;
    end
  endgenerate

  assign ramp2_lvl = |is_ramp2;
  assign coast_lvl = |is_coast;
  assign fault_lvl = |is_fault;
  assign fault_rise = fault_lvl && !fault_prev_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_prev_ff <= 1'b0;
    end else if (ce) begin
      fault_prev_ff <= fault_lvl;
    end
  end
endmodule

// file: hdl/dicl_delay_timer.sv
// Restart delay timer counting whole delay ticks
// Assumes a 250 MHz clock; one tick per millisecond
`timescale 1ns/1ps
`include "dicl_cfg.svh"
module dicl_delay_timer
  import dicl_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic start, // Load and begin counting
  input wire logic abort, // Stop counting
  input wire logic [`DICL_DELAY_W-1:0] delay, // Delay in ticks
  output logic done // One-cycle pulse at expiry
);
  logic [`DICL_TICK_W-1:0] tick_ff;
  logic [`DICL_DELAY_W-1:0] left_ff;
  logic busy_ff;
  logic tick;

  assign tick = tick_ff == `DICL_TICK_DIV - `DICL_TICK_ONE;
  assign done = busy_ff && tick && left_ff == `DICL_DELAY_ONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_ff <= '0;
      left_ff <= '0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (start || abort || !busy_ff || tick) begin
        tick_ff <= '0;
      end else begin
        tick_ff <= tick_ff + `DICL_TICK_ONE;
      end
      if (abort) begin
        busy_ff <= 1'b0;
      end else if (start) begin
        busy_ff <= 1'b1;
        left_ff <= delay;
      end else if (done) begin
        busy_ff <= 1'b0;
      end else if (busy_ff && tick) begin
        left_ff <= left_ff - `DICL_DELAY_ONE;
      end
    end
  end
endmodule

// file: hdl/dicl_top.sv
// Drive input command logic: ramp select, coast stop, external fault
// Assumes AXI4-Lite master on aclk; ramp generator follows the outputs
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dicl_cfg.svh"
// Notes on behaviour
// - Second ramp input selects second ramp times
// - Released input restores first ramp times
// - Ramp set changes at once, mid-ramp
// - Input acts only when method is terminal
// - Coast input turns output off
// - Coast release resumes only with run
// - Restart from zero or matched speed
// - Restart waits delay; zero means none
// - Each input polarity is configurable
// - Fault input trips, stops, reports code
// - Trip holds until reset; then stop
// - Trip coasts motor, raises alarm immediately
// - Reset release restarts if run active
// - Trip only on off-to-on edge
// - Trip history kept until reset
module dicl_top
  import dicl_pkg::*;
(
  input wire logic aclk, // Clock, 250 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [`DICL_TERM_N-1:0] term_in, // Input terminals
  input wire logic run_cmd, // Run command
  input wire logic fault_reset, // Trip reset command
  input wire logic [`DICL_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [`DICL_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic drive_enable, // Output stage on
  output logic restart_match, // Restart from motor speed
  output logic [`DICL_RAMP_W-1:0] accel_time, // Active accel time
  output logic [`DICL_RAMP_W-1:0] decel_time, // Active decel time
  output logic alarm_out, // Alarm output
  output logic [7:0] error_code, // Shown error code
  output logic irq // Level interrupt
);
  // ****************************************
  // Registers
  // ****************************************
  logic run_ctl_ff;
  logic [`DICL_RAMP_W-1:0] accel_time_first_ff;
  logic [`DICL_RAMP_W-1:0] decel_time_first_ff;
  logic [`DICL_RAMP_W-1:0] accel_time_second_ff;
  logic [`DICL_RAMP_W-1:0] decel_time_second_ff;
  logic [1:0] second_ramp_method_ff;
  logic [`DICL_DELAY_W-1:0] coast_restart_delay_ff;
  logic coast_restart_mode_ff;
  logic [`DICL_TERM_N-1:0] input_polarity_settings_ff;
  logic [`DICL_TERM_N*`DICL_FUNC_W-1:0] input_function_assignments_ff;
  logic [`DICL_IRQ_W-1:0] irq_stat_ff;
  logic [`DICL_IRQ_W-1:0] irq_en_ff;
  logic [`DICL_HIST_W-1:0] trip_hist_ff;
  logic trip_ff;
  logic rst_prev_ff;
  dicl_state_t state_ff;
  dicl_state_t nxt_state;

  logic ramp2_lvl;
  logic coast_lvl;
  logic fault_rise;
  logic delay_done;
  logic timer_start;
  logic timer_abort;
  logic run_any;
  logic rst_release;

  // ****************************************
  // Terminal front end and timer
  // ****************************************
  dicl_term_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .term_in(term_in),
    .pol_low(input_polarity_settings_ff),
    .func_sel(input_function_assignments_ff),
    .ramp2_lvl(ramp2_lvl),
    .coast_lvl(coast_lvl),
    .fault_rise(fault_rise)
  );

  dicl_delay_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(timer_start),
    .abort(timer_abort),
    .delay(coast_restart_delay_ff),
    .done(delay_done)
  );

  // ****************************************
  // Run state machine
  // ****************************************
  assign run_any = run_cmd || run_ctl_ff;
  assign rst_release = rst_prev_ff && !fault_reset;
  wire delay_zero = coast_restart_delay_ff == '0;
  wire trip_set = fault_rise;
  wire trip_hold = trip_ff || trip_set;
  wire coast_leave = state_ff == DICL_COASTING && !coast_lvl && run_any;
  assign timer_start = coast_leave && !delay_zero && !trip_hold;
  assign timer_abort = state_ff == DICL_WAITING &&
    (coast_lvl || !run_any || trip_hold);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DICL_STOPPED: begin
        if (run_any && !trip_hold && !fault_reset && !coast_lvl) begin
          nxt_state = DICL_RUNNING;
        end
      end
      DICL_RUNNING: begin
        if (coast_lvl) begin
          nxt_state = DICL_COASTING;
        end else if (!run_any) begin
          nxt_state = DICL_STOPPED;
        end
      end
      DICL_COASTING: begin
        if (!coast_lvl && !run_any) begin
          nxt_state = DICL_STOPPED;
        end else if (coast_leave && delay_zero) begin
          nxt_state = DICL_RUNNING;
        end else if (coast_leave) begin
          nxt_state = DICL_WAITING;
        end
      end
      DICL_WAITING: begin
        if (coast_lvl) begin
          nxt_state = DICL_COASTING;
        end else if (!run_any) begin
          nxt_state = DICL_STOPPED;
        end else if (delay_done) begin
          nxt_state = DICL_RUNNING;
        end
      end
      default: nxt_state = DICL_STOPPED;
    endcase
    if (trip_hold || fault_reset) begin
      nxt_state = DICL_STOPPED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= DICL_STOPPED;
      trip_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
      trip_hist_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      rst_prev_ff <= fault_reset;
      if (trip_set) begin
        trip_ff <= 1'b1;
      end else if (fault_reset) begin
        trip_ff <= 1'b0;
      end
      if (trip_set && trip_hist_ff != `DICL_HIST_MAX) begin
        trip_hist_ff <= trip_hist_ff + `DICL_HIST_ONE;
      end else if (rst_release) begin
        trip_hist_ff <= '0;
      end
    end
  end

  // ****************************************
  // Drive outputs
  // ****************************************
  wire use_second = ramp2_lvl &&
    second_ramp_method_ff == `DICL_METHOD_TERM;
  wire [`DICL_RAMP_W-1:0] nxt_accel = use_second ?
    accel_time_second_ff : accel_time_first_ff;
  wire [`DICL_RAMP_W-1:0] nxt_decel = use_second ?
    decel_time_second_ff : decel_time_first_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_enable <= 1'b0;
      restart_match <= 1'b0;
      accel_time <= `DICL_ACC_RST;
      decel_time <= `DICL_DEC_RST;
      alarm_out <= 1'b0;
      error_code <= '0;
    end else if (ce) begin
      drive_enable <= nxt_state == DICL_RUNNING;
      if (nxt_state == DICL_RUNNING && state_ff != DICL_RUNNING) begin
        restart_match <= coast_restart_mode_ff &&
          state_ff != DICL_STOPPED;
      end
      accel_time <= nxt_accel;
      decel_time <= nxt_decel;
      alarm_out <= trip_hold && !fault_reset;
      error_code <= (trip_hold && !fault_reset) ?
        `DICL_FAULT_CODE : 8'h00;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  wire [`DICL_IRQ_W-1:0] irq_evt = {timer_start || coast_leave,
    state_ff == DICL_RUNNING && nxt_state == DICL_COASTING, trip_set};

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held_ff;
  logic w_held_ff;
  logic [`DICL_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire [`DICL_ADDR_W-1:0] wa = awaddr_ff & ~8'h03;
  wire wr_ok = wa <= `DICL_OFS_IRQ_EN && wa != `DICL_OFS_STATUS &&
    wa != `DICL_OFS_IRQ_STAT;
  wire [`DICL_ADDR_W-1:0] ra = s_axi_araddr & ~8'h03;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_clr = wr_go && wa == `DICL_OFS_IRQ_CLR;
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      `DICL_OFS_CTRL: rd_mux = {31'h0, run_ctl_ff};
      `DICL_OFS_ACC1: rd_mux = {16'h0, accel_time_first_ff};
      `DICL_OFS_DEC1: rd_mux = {16'h0, decel_time_first_ff};
      `DICL_OFS_ACC2: rd_mux = {16'h0, accel_time_second_ff};
      `DICL_OFS_DEC2: rd_mux = {16'h0, decel_time_second_ff};
      `DICL_OFS_METHOD: rd_mux = {30'h0, second_ramp_method_ff};
      `DICL_OFS_DELAY: rd_mux = {16'h0, coast_restart_delay_ff};
      `DICL_OFS_MODE: rd_mux = {31'h0, coast_restart_mode_ff};
      `DICL_OFS_POL: rd_mux = {27'h0, input_polarity_settings_ff};
      `DICL_OFS_ASSIGN: rd_mux = input_function_assignments_ff[31:0];
      `DICL_OFS_STATUS: rd_mux = {22'h0, error_code, trip_ff,
        drive_enable};
      `DICL_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
      `DICL_OFS_IRQ_CLR: rd_mux = 32'h0;
      `DICL_OFS_IRQ_EN: rd_mux = {29'h0, irq_en_ff};
      `DICL_OFS_HIST: rd_mux = {24'h0, trip_hist_ff};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DICL_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DICL_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `DICL_RESP_OKAY : `DICL_RESP_SLVERR;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `DICL_RESP_OKAY : `DICL_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Configuration writes; strobes ignored, whole word written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ctl_ff <= 1'b0;
      accel_time_first_ff <= `DICL_ACC_RST;
      decel_time_first_ff <= `DICL_DEC_RST;
      accel_time_second_ff <= `DICL_ACC_RST;
      decel_time_second_ff <= `DICL_DEC_RST;
      second_ramp_method_ff <= `DICL_METHOD_TERM;
      coast_restart_delay_ff <= '0;
      coast_restart_mode_ff <= 1'b0;
      input_polarity_settings_ff <= '0;
      input_function_assignments_ff <= `DICL_ASSIGN_RST;
      irq_en_ff <= '0;
    end else if (ce && wr_go) begin
      case (wa)
        `DICL_OFS_CTRL: run_ctl_ff <= wdata_ff[0];
        `DICL_OFS_ACC1: accel_time_first_ff <= wdata_ff[15:0];
        `DICL_OFS_DEC1: decel_time_first_ff <= wdata_ff[15:0];
        `DICL_OFS_ACC2: accel_time_second_ff <= wdata_ff[15:0];
        `DICL_OFS_DEC2: decel_time_second_ff <= wdata_ff[15:0];
        `DICL_OFS_METHOD: second_ramp_method_ff <= wdata_ff[1:0];
        `DICL_OFS_DELAY: coast_restart_delay_ff <= wdata_ff[15:0];
        `DICL_OFS_MODE: coast_restart_mode_ff <= wdata_ff[0];
        `DICL_OFS_POL: input_polarity_settings_ff <= wdata_ff[4:0];
        `DICL_OFS_ASSIGN: input_function_assignments_ff <=
          {input_function_assignments_ff[39:32], wdata_ff};
        `DICL_OFS_IRQ_EN: irq_en_ff <= wdata_ff[2:0];
        default: run_ctl_ff <= run_ctl_ff;
      endcase
    end
  end

  // Sticky events; set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_ff <= (irq_stat_ff &
        ~(wr_clr ? wdata_ff[2:0] : 3'h0)) | irq_evt;
      irq <= |(((irq_stat_ff & ~(wr_clr ? wdata_ff[2:0] : 3'h0)) |
        irq_evt) & irq_en_ff);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_trip_blocks_drive: assert property (@(posedge aclk) disable iff
    (!aresetn) ce && trip_ff |=> !drive_enable)
    else $error("drive enabled while trip latched");
  a_trip_alarm_now: assert property (@(posedge aclk) disable iff
    (!aresetn) ce && fault_rise && !fault_reset |=> alarm_out &&
    error_code == `DICL_FAULT_CODE)
    else $error("alarm not raised on fault edge");
  a_coast_cuts_out: assert property (@(posedge aclk) disable iff
    (!aresetn) ce && coast_lvl |=> !drive_enable)
    else $error("drive enabled during coast");
  a_ramp_select: assert property (@(posedge aclk) disable iff
    (!aresetn) ce |=> accel_time == ($past(use_second) ?
    $past(accel_time_second_ff) : $past(accel_time_first_ff)))
    else $error("wrong accel set");
  a_trip_held: assert property (@(posedge aclk) disable iff
    (!aresetn) ce && trip_ff && !fault_reset |=> trip_ff)
    else $error("trip dropped without reset");
  a_trip_edge_only: assert property (@(posedge aclk) disable iff
    (!aresetn) ce && !trip_ff && !fault_rise |=> !trip_ff)
    else $error("trip latched without rising edge");
endmodule

// file: bench/dicl_contacts.sv
// Contact model for the switches wired to the input terminals
// Assumes terminal 1 ramp, 2 coast, 3 fault, as set at reset
`timescale 1ns/1ps
module dicl_contacts (
  input wire logic ramp2_on, // Ramp switch closed
  input wire logic coast_on, // Coast switch closed
  input wire logic fault_on, // Fault contact closed
  input wire logic [4:0] pol_low, // Inverted wiring
  output logic [4:0] term_in // Terminal levels
);
  // ****************
  // Terminal levels
  // ****************
  assign term_in = {1'b0, fault_on, coast_on, ramp2_on, 1'b0} ^ pol_low;
endmodule

// file: bench/dicl_top_test.sv
// Self-checking bench: AXI4-Lite tasks and terminal sequences
// Assumes the reset register map and a 250 MHz clock
`timescale 1ns/1ps
`include "dicl_cfg.svh"
module dicl_top_test;
  localparam logic [1:0] OK = `DICL_RESP_OKAY;
  localparam logic [1:0] ER = `DICL_RESP_SLVERR;
  logic aclk = 0, aresetn = 0, run_cmd = 0, fault_reset = 0;
  logic [7:0] awaddr = 0, araddr = 0, error_code;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic ramp2_on = 0, coast_on = 0, fault_on = 0;
  logic [4:0] pol_low = 0, term_in;
  logic drive_enable, restart_match, alarm_out, irq;
  logic [15:0] accel_time, decel_time;
  int mismatches = 0, n_tests = 0;
  // ****************
  // Design and contacts
  // ****************
  dicl_contacts u_dicl_contacts (.ramp2_on(ramp2_on), .coast_on(coast_on),
    .fault_on(fault_on), .pol_low(pol_low), .term_in(term_in));
  dicl_top u_dicl_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .term_in(term_in), .run_cmd(run_cmd), .fault_reset(fault_reset),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .drive_enable(drive_enable),
    .restart_match(restart_match), .accel_time(accel_time),
    .decel_time(decel_time), .alarm_out(alarm_out),
    .error_code(error_code), .irq(irq));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk(32'(bresp), 32'(e));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [1:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, x);
    chk(32'(rresp), 32'(e));
    rready <= 1'b0;
  endtask
  task automatic st;
    repeat (6) @(posedge aclk);
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************
  // Clock, watchdog, sequence
  // ****************
  initial forever #2 aclk = ~aclk;
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(accel_time), 32'(`DICL_ACC_RST));
    rd(`DICL_OFS_ASSIGN, 32'h0c0b0900, OK);
    rd(8'h3c, 32'h0, ER);
    wr(`DICL_OFS_STATUS, 32'h1, ER);
    wr(`DICL_OFS_ACC1, 32'h10, OK);
    wr(`DICL_OFS_DEC1, 32'h20, OK);
    wr(`DICL_OFS_ACC2, 32'h30, OK);
    wr(`DICL_OFS_DEC2, 32'h40, OK);
    wr(`DICL_OFS_IRQ_EN, 32'h1, OK);
    chk({accel_time, decel_time}, 32'h00100020);
    run_cmd <= 1'b1;
    ramp2_on <= 1'b1;
    st;
    chk({accel_time, decel_time}, 32'h00300040);
    chk(32'(drive_enable), 32'h1);
    ramp2_on <= 1'b0;
    st;
    chk(32'(accel_time), 32'h10);
    wr(`DICL_OFS_METHOD, 32'h1, OK);
    ramp2_on <= 1'b1;
    st;
    chk(32'(accel_time), 32'h10);
    wr(`DICL_OFS_METHOD, 32'h0, OK);
    st;
    chk(32'(accel_time), 32'h30);
    ramp2_on <= 1'b0;
    wr(`DICL_OFS_MODE, 32'h1, OK);
    for (int m = 1; m >= 0; m--) begin
      wr(`DICL_OFS_MODE, 32'(m), OK);
      coast_on <= 1'b1;
      st;
      chk(32'(drive_enable), 32'h0);
      coast_on <= 1'b0;
      st;
      chk({31'h0, drive_enable}, 32'h1);
      chk(32'(restart_match), 32'(m));
    end
    pol_low <= 5'h04;
    wr(`DICL_OFS_POL, 32'h4, OK);
    st;
    chk(32'(drive_enable), 32'h1);
    coast_on <= 1'b1;
    st;
    chk(32'(drive_enable), 32'h0);
    run_cmd <= 1'b0;
    st;
    coast_on <= 1'b0;
    st;
    chk(32'(drive_enable), 32'h0);
    run_cmd <= 1'b1;
    wr(`DICL_OFS_DELAY, 32'h1, OK);
    coast_on <= 1'b1;
    st;
    coast_on <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(32'(drive_enable), 32'h0);
    coast_on <= 1'b1;
    wr(`DICL_OFS_DELAY, 32'h0, OK);
    coast_on <= 1'b0;
    st;
    chk(32'(drive_enable), 32'h1);
    fault_on <= 1'b1;
    st;
    chk({alarm_out, drive_enable, error_code}, 32'h212);
    chk(32'(irq), 32'h1);
    fault_on <= 1'b0;
    coast_on <= 1'b1;
    st;
    coast_on <= 1'b0;
    st;
    chk({alarm_out, drive_enable}, 32'h2);
    rd(`DICL_OFS_STATUS, 32'h4a, OK);
    rd(`DICL_OFS_HIST, 32'h1, OK);
    rd(`DICL_OFS_IRQ_STAT, 32'h7, OK);
    wr(`DICL_OFS_IRQ_EN, 32'h0, OK);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(`DICL_OFS_IRQ_EN, 32'h1, OK);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(`DICL_OFS_IRQ_CLR, 32'h7, OK);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    rd(`DICL_OFS_IRQ_CLR, 32'h0, OK);
    fault_reset <= 1'b1;
    st;
    chk(32'(alarm_out), 32'h0);
    fault_reset <= 1'b0;
    st;
    chk({drive_enable, error_code}, 32'h100);
    rd(`DICL_OFS_HIST, 32'h0, OK);
    fault_on <= 1'b1;
    st;
    fault_reset <= 1'b1;
    st;
    fault_reset <= 1'b0;
    st;
    fault_on <= 1'b0;
    st;
    chk({alarm_out, drive_enable}, 32'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({accel_time, 8'h0, error_code}, {`DICL_ACC_RST, 16'h0});
    close_out;
  end
endmodule
